/* File: core/ttc_cfg.svh */
// Constants for the thermal throttle controller: offsets, fields, resets.
// Assumes a 200 MHz core clock and an AXI4-Lite register bus.
//
// What this block does
// - Circuit activates at a fixed trip temperature software cannot change.
// - Interrupt requests are latched while throttled, released only while clock runs.
// - Automatic and on-demand sources exist; automatic wins when both enabled.
// - Automatic offers clock gating or operating-point sub-modes, engaging at trip.
// - Operating-point mode lowers the point when hot, restores last request after.
// - Operating-point mode wins; clock gating joins if still hot after lowering.
// - A faster software request during throttling waits until throttling ends.
// - A slower software request during throttling is applied at once.
// - Clock gating alternates core clock on and off at fifty percent.
// - Modulation period shortens in inverse proportion as core frequency rises.
// - Cooling stops modulation and deactivates, with hysteresis around the trip.
// - Automatic duty is fixed; automatic throttling needs no software.
// - A factory diode offset value is readable by software.
// - Writing the on-demand bit activates the circuit regardless of temperature.
// - On-demand three-bit duty sets clock-on from zero to seven eighths.
// - Active-low over-temperature output asserts at or above the trip point.
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define TTC_OFF_CTRL 8'h00
`define TTC_OFF_STAT 8'h04
`define TTC_OFF_IRQ_STAT 8'h08
`define TTC_OFF_IRQ_MASK 8'h0c
`define TTC_OFF_OP_REQ 8'h10
`define TTC_OFF_OP_CUR 8'h14
`define TTC_OFF_DIODE 8'h18
`define TTC_OFF_CORE_FREQ 8'h1c

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define TTC_CTRL_ODM_DUTY_LO 1
`define TTC_CTRL_ODM_EN 4
`define TTC_CTRL_CG_EN 8
`define TTC_CTRL_OP_EN 9
`define TTC_CTRL_RST 32'h0000_0300

// ----------------------------------------------------------------
// Thermal and timing constants
// ----------------------------------------------------------------
`define TTC_TRIP_TEMP 8'd100
`define TTC_HYST_MARGIN 8'd2
`define TTC_AUTO_DUTY 3'd4
`define TTC_DIODE_OFFSET 8'h05
`define TTC_OP_THROTTLED 4'h1
`define TTC_OP_RST 4'hf
`define TTC_FREQ_RST 8'd20
`define TTC_MOD_SCALE 16'd4096

// Interrupt status bits
`define TTC_IRQ_HOT_RISE 0
`define TTC_IRQ_HOT_FALL 1
`define TTC_IRQ_OP_DEFER 2

`endif

/* File: core/ttc_gate_if.sv */
// Link between the throttle core and the clock modulator.
// Assumes one clock for both ends.
`timescale 1ns/1ps
`default_nettype none
interface ttc_gate_if;
   logic active;
   logic [2:0] duty;
   logic [7:0] core_freq;
   logic clk_on;
   modport ctl (output active, output duty, output core_freq, input clk_on);
   modport mod (input active, input duty, input core_freq, output clk_on);
endinterface
`default_nettype wire

/* File: core/ttc_irq_hold.sv */
// Interrupt latch: holds requests while the core clock is stopped.
// Assumes requests are one-cycle pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module ttc_irq_hold
   import ttc_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic SYS_RST,
   // Requests in and out
   input wire logic req_in,
   input wire logic clk_on,
   output logic req_out
);
   logic pend_ff;

   // latch interrupts
   // Set wins over clear so no request is lost.
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pend_ff <= 1'b0;
      end else if (req_in) begin
         pend_ff <= 1'b1;
      end else if (clk_on) begin
         pend_ff <= 1'b0;
      end
   end

   assign req_out = pend_ff && clk_on;
endmodule
`default_nettype wire

/* File: core/ttc_modulator.sv */
// Clock modulator: eighth-step duty, frequency-scaled period.
// Assumes the core clock drives it and gates act on cycle edges.
`timescale 1ns/1ps
`default_nettype none
`include "ttc_cfg.svh"
module ttc_modulator
   import ttc_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic SYS_RST,
   // Control
   ttc_gate_if.mod gate
);
   logic [15:0] tick_ff;
   logic [2:0] phase_ff;
   logic on_ff;
   logic [15:0] slice;

   // period scale
   // Slice shrinks as the core frequency grows, so the period falls in inverse proportion.
   assign slice = (gate.core_freq == 8'd0) ? `TTC_MOD_SCALE :
                  16'(`TTC_MOD_SCALE / {8'd0, gate.core_freq});

   // Slice counter; one phase step per elapsed slice
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         tick_ff <= 16'h0000;
         phase_ff <= 3'h0;
      end else if (!gate.active) begin
         tick_ff <= 16'h0000;
         phase_ff <= 3'h0;
      end else if (tick_ff + 16'h0001 >= slice) begin
         tick_ff <= 16'h0000;
         phase_ff <= phase_ff + 3'h1;
      end else begin
         tick_ff <= tick_ff + 16'h0001;
      end
   end

   // clean edges
   // Registered enable only changes between cycles, never mid-pulse.
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         on_ff <= 1'b1;
      end else begin
         on_ff <= !gate.active || (phase_ff < gate.duty);
      end
   end

   assign gate.clk_on = on_ff;
endmodule
`default_nettype wire

/* File: core/ttc_pkg.sv */
// Types for the thermal throttle controller.
// Assumes the constants header is included beside it.
package ttc_pkg;
   typedef enum logic [1:0] {
      TTC_IDLE = 2'b00,
      TTC_HOT = 2'b01
   } ttc_therm_t;
   typedef logic [3:0] ttc_op_t;
endpackage

/* File: core/ttc_top.sv */
// Thermal throttle controller top: AXI4-Lite registers, trip detect,
// source arbitration, operating-point control, interrupts.
// Assumes the sensor temperature is synchronous to CLOCK.
// Assumes at most one write and one read in flight on the bus.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ttc_cfg.svh"
module ttc_top
   import ttc_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic SYS_RST,
   // AXI4-Lite write address
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   // AXI4-Lite write data
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // AXI4-Lite write response
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read address
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   // AXI4-Lite read data
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Sensor and core
   input wire logic [7:0] DIE_TEMP,
   input wire logic CORE_IRQ_IN,
   output logic CORE_IRQ_OUT,
   output logic CORE_CLK_EN,
   output logic [3:0] OP_POINT,
   output logic OVER_TEMP_OUT_N,
   output logic IRQ
);
   // Control link to the clock modulator
   ttc_gate_if gate ();

   // Software-visible registers
   logic [31:0] ctrl_ff;
   logic [2:0] irq_stat_ff;
   logic [2:0] irq_mask_ff;
   ttc_op_t op_req_ff;
   ttc_op_t op_cur_ff;
   logic [7:0] freq_ff;
   // Thermal and operating-point state
   ttc_therm_t therm_ff;
   logic hot_d_ff;
   logic defer_ff;
   // Bus capture and responses
   logic aw_got_ff, w_got_ff;
   logic [7:0] aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic bvalid_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   // Decoded controls and events
   logic hot, op_on, cg_on, odm_on, op_thr, cg_auto;
   logic wr_go, rd_go, wr_op, rd_istat;
   logic [2:0] ev;

   // ----------------------------------------------------------------
   // Trip detection
   // ----------------------------------------------------------------
   // hysteresis trip
   // Fixed thresholds; lower release point prevents chatter near the trip.
   // The reading is trusted as is; the hysteresis is the only filter.
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         therm_ff <= TTC_IDLE;
      end else begin
         case (therm_ff)
            TTC_IDLE:
               if (DIE_TEMP >= `TTC_TRIP_TEMP) therm_ff <= TTC_HOT;
            TTC_HOT:
               if (DIE_TEMP < `TTC_TRIP_TEMP - `TTC_HYST_MARGIN) begin
                  therm_ff <= TTC_IDLE;
               end
            default: therm_ff <= TTC_IDLE;
         endcase
      end
   end
   // Hot level shared by the arbiter, the pin and the events
   assign hot = (therm_ff == TTC_HOT);

   assign OVER_TEMP_OUT_N = !hot;

   // ----------------------------------------------------------------
   // Source arbitration
   // ----------------------------------------------------------------
   // Enable bits decoded once for the arbiter
   assign op_on = ctrl_ff[`TTC_CTRL_OP_EN];
   assign cg_on = ctrl_ff[`TTC_CTRL_CG_EN];
   assign odm_on = ctrl_ff[`TTC_CTRL_ODM_EN];
   assign op_thr = hot && op_on;
   // clock gating backup
   // Clock gating joins at trip if operating-point mode is off, else only once the lowered point is in force and still hot.
   assign cg_auto = hot && cg_on &&
                    (!op_on || op_cur_ff <= `TTC_OP_THROTTLED);
   // fixed auto duty
   // On-demand duty is ignored while automatic gating runs.
   assign gate.active = cg_auto || odm_on;
   assign gate.duty = cg_auto ? `TTC_AUTO_DUTY :
                      ctrl_ff[`TTC_CTRL_ODM_DUTY_LO +: 3];
   assign gate.core_freq = freq_ff;
   assign CORE_CLK_EN = gate.clk_on;

   // Clock modulator: frequency-scaled period, eighth-step duty
   ttc_modulator u_mod (
      .CLOCK(CLOCK),
      .SYS_RST(SYS_RST),
      .gate(gate)
   );

   // Interrupt holder across stopped-clock stretches
   ttc_irq_hold u_hold (
      .CLOCK(CLOCK),
      .SYS_RST(SYS_RST),
      .req_in(CORE_IRQ_IN),
      .clk_on(gate.clk_on),
      .req_out(CORE_IRQ_OUT)
   );

   // ----------------------------------------------------------------
   // Operating point
   // ----------------------------------------------------------------
   // point selection
   // Lower code means lower frequency. Faster requests wait for cooling.
   // Limitation: every throttled request above code 0 lands on one fixed code.
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         op_cur_ff <= `TTC_OP_RST;
         defer_ff <= 1'b0;
      end else if (op_thr) begin
         defer_ff <= (op_req_ff > `TTC_OP_THROTTLED);
         op_cur_ff <= (op_req_ff < `TTC_OP_THROTTLED) ? op_req_ff :
                      `TTC_OP_THROTTLED;
      end else begin
         defer_ff <= 1'b0;
         op_cur_ff <= op_req_ff;
      end
   end
   assign OP_POINT = op_cur_ff;

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   // Readies drop while a response waits, so no second write overtakes it
   // and no read answer is overwritten before the master takes it.
   assign AWREADY = !aw_got_ff && !bvalid_ff;
   assign WREADY = !w_got_ff && !bvalid_ff;
   assign ARREADY = !rvalid_ff;
   assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
   assign rd_go = ARVALID && ARREADY;
   assign wr_op = wr_go && w_strb_ff[0] && aw_addr_ff == `TTC_OFF_OP_REQ;
   assign rd_istat = rd_go && ARADDR == `TTC_OFF_IRQ_STAT;

   // Address and data captured independently, in either order
   // Each channel's ready drops once its item is held
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
      end else if (wr_go) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_got_ff <= 1'b1;
            aw_addr_ff <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_got_ff <= 1'b1;
            w_data_ff <= WDATA;
            w_strb_ff <= WSTRB;
         end
      end
   end

   // Register writes; only the low byte lanes carry fields
   // Read-only and unmapped offsets take no effect on a write
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ctrl_ff <= `TTC_CTRL_RST;
         irq_mask_ff <= 3'h0;
         op_req_ff <= `TTC_OP_RST;
         freq_ff <= `TTC_FREQ_RST;
      end else if (wr_go) begin
         case (aw_addr_ff)
            `TTC_OFF_CTRL: begin
               if (w_strb_ff[0]) ctrl_ff[7:0] <= {3'h0, w_data_ff[4:0]};
               if (w_strb_ff[1]) ctrl_ff[15:8] <= {6'h0, w_data_ff[9:8]};
            end
            `TTC_OFF_IRQ_MASK:
               if (w_strb_ff[0]) irq_mask_ff <= w_data_ff[2:0];
            `TTC_OFF_OP_REQ:
               if (w_strb_ff[0]) op_req_ff <= w_data_ff[3:0];
            `TTC_OFF_CORE_FREQ:
               if (w_strb_ff[0]) freq_ff <= w_data_ff[7:0];
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   // Write response
   // SLVERR past the map or off a word boundary
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= 2'b00;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (aw_addr_ff > `TTC_OFF_CORE_FREQ ||
                      aw_addr_ff[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end else if (BREADY) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Read data; unmapped addresses answer SLVERR with zero
   // Status is sampled at the address handshake, a cycle before RVALID
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= 2'b00;
      end else if (rd_go) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= 2'b00;
         case (ARADDR)
            `TTC_OFF_CTRL: rdata_ff <= ctrl_ff;
            `TTC_OFF_STAT:
               rdata_ff <= {27'h0, defer_ff, op_thr, cg_auto,
                            gate.active, hot};
            `TTC_OFF_IRQ_STAT: rdata_ff <= {29'h0, irq_stat_ff};
            `TTC_OFF_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
            `TTC_OFF_OP_REQ: rdata_ff <= {28'h0, op_req_ff};
            `TTC_OFF_OP_CUR: rdata_ff <= {28'h0, op_cur_ff};
            `TTC_OFF_DIODE: rdata_ff <= {24'h0, `TTC_DIODE_OFFSET};
            `TTC_OFF_CORE_FREQ: rdata_ff <= {24'h0, freq_ff};
            default: begin
               rdata_ff <= 32'h0000_0000;
               rresp_ff <= 2'b10;
            end
         endcase
      end else if (RREADY) begin
         rvalid_ff <= 1'b0;
      end
   end

   // Responses leave straight from their registers
   assign BVALID = bvalid_ff;
   assign BRESP = bresp_ff;
   assign RVALID = rvalid_ff;
   assign RDATA = rdata_ff;
   assign RRESP = rresp_ff;

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   // Previous hot level; resets to the idle level of hot, so leaving
   // reset never shows a false edge
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         hot_d_ff <= 1'b0;
      end else begin
         hot_d_ff <= hot;
      end
   end
   // One-cycle events; a deferred request counts only when its byte
   // actually lands in the request register
   assign ev[`TTC_IRQ_HOT_RISE] = hot && !hot_d_ff;
   assign ev[`TTC_IRQ_HOT_FALL] = !hot && hot_d_ff;
   assign ev[`TTC_IRQ_OP_DEFER] = wr_op && op_thr &&
                                  w_data_ff[3:0] > `TTC_OP_THROTTLED;

   // Sticky status; read clears, but a same-cycle event stays set
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         irq_stat_ff <= 3'h0;
      end else begin
         irq_stat_ff <= (rd_istat ? 3'h0 : irq_stat_ff) | ev;
      end
   end

   // Level interrupt while any unmasked status bit is set
   assign IRQ = |(irq_stat_ff & irq_mask_ff);
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Bench for the thermal throttle controller: bus, heating, gating.
// Assumes the sensor model beside it and the checker bound to the top.
`timescale 1ns/1ps
`default_nettype none
`include "ttc_cfg.svh"
module tb_top;
   // Periods at core frequency codes 255 and 128
   localparam int SLP = 8 * (`TTC_MOD_SCALE / 255);
   localparam int SLQ = 8 * (`TTC_MOD_SCALE / 128);
   logic CLOCK, SYS_RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic CORE_IRQ_IN, fast, AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic CORE_IRQ_OUT, CORE_CLK_EN, OVER_TEMP_OUT_N, IRQ;
   logic [7:0] AWADDR, ARADDR, tgt, DIE_TEMP;
   logic [31:0] WDATA, RDATA, rd;
   logic [3:0] WSTRB, OP_POINT;
   logic [1:0] BRESP, RRESP, rsp;
   int errors, n_checks;
   ttc_top u_ttc_top (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .AWADDR(AWADDR),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
      .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY), .DIE_TEMP(DIE_TEMP), .CORE_IRQ_IN(CORE_IRQ_IN),
      .CORE_IRQ_OUT(CORE_IRQ_OUT), .CORE_CLK_EN(CORE_CLK_EN),
      .OP_POINT(OP_POINT), .OVER_TEMP_OUT_N(OVER_TEMP_OUT_N), .IRQ(IRQ));
   ttc_sensor_model u_ttc_sensor_model (.CLOCK(CLOCK), .target(tgt),
      .fast(fast), .die_temp(DIE_TEMP));
   // Clock at 5 ns
   initial begin
      CLOCK = 1'b0;
      forever #2.5 CLOCK = ~CLOCK;
   end
   task automatic stop_test();
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %0t word %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk_word({31'h0, g}, {31'h0, e});
   endtask
   // A bound that ran out ends the run at once
   task automatic guard(input int i);
      if (i >= 3000) begin
         chk_bit(1'b0, 1'b1);
         stop_test();
      end
   endtask
   // Wait for a level on hot output (0), clock enable (1), request (2)
   task automatic wait_for(input int s, input logic v);
      int i;
      for (i = 0; i < 3000; i++) begin
         @(posedge CLOCK);
         if ((s == 0 ? OVER_TEMP_OUT_N : s == 1 ? CORE_CLK_EN :
              CORE_IRQ_OUT) === v) break;
      end
      guard(i);
   endtask
   // Write with both channels offered together, each held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge CLOCK);
      AWADDR <= a;
      WDATA <= d;
      {AWVALID, WVALID, BREADY} <= 3'h7;
      for (i = 0; i < 3000; i++) begin
         @(posedge CLOCK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
         if (BVALID) break;
      end
      rsp = BRESP;
      BREADY <= 1'b0;
      guard(i);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      int i;
      @(posedge CLOCK);
      ARADDR <= a;
      {ARVALID, RREADY} <= 2'h3;
      for (i = 0; i < 3000; i++) begin
         @(posedge CLOCK);
         if (ARREADY) ARVALID <= 1'b0;
         if (RVALID) break;
      end
      {rsp, rd} = {RRESP, RDATA};
      RREADY <= 1'b0;
      guard(i);
   endtask
   // Count enabled cycles over one period, from a rise when aligned
   task automatic meas(input int per, input int exp, input logic al);
      int n;
      if (al) wait_for(1, 1'b0);
      wait_for(1, 1'b1);
      n = 1;
      repeat (per - 1) begin
         @(posedge CLOCK);
         n += int'(CORE_CLK_EN);
      end
      chk_word(32'(n), 32'(exp));
   endtask
   task automatic t_reset();
      logic [7:0] a[6] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c};
      logic [31:0] v[6] = '{32'h300, 32'h0, 32'hf, 32'hf, 32'h5, 32'h14};
      for (int k = 0; k < 6; k++) begin
         rd_reg(a[k]);
         chk_word(rd, v[k]);
      end
      chk_bit(OVER_TEMP_OUT_N, 1'b1);
      wr(8'h18, 32'h0);
      rd_reg(8'h18);
      chk_word(rd, 32'h5);
      rd_reg(8'h20);
      chk_word({rsp, rd[29:0]}, 32'h8000_0000);
      wr(8'h20, 32'h1);
      chk_word({30'h0, rsp}, 32'h2);
   endtask
   task automatic t_hot();
      wr(8'h0c, 32'h0);
      wr(8'h1c, 32'hff);
      wr(8'h10, 32'h8);
      tgt <= 8'h64;
      wait_for(0, 1'b0);
      chk_bit(IRQ, 1'b0);
      wait_for(1, 1'b0);
      chk_word({28'h0, OP_POINT}, 32'h1);
      wr(8'h0c, 32'h7);
      chk_bit(IRQ, 1'b1);
      rd_reg(8'h08);
      chk_word(rd, 32'h1);
      wr(8'h10, 32'hc);
      @(posedge CLOCK);
      chk_word({28'h0, OP_POINT}, 32'h1);
      rd_reg(8'h04);
      chk_word(rd, 32'h1f);
      meas(SLP, SLP / 2, 1'b1);
      wr(8'h10, 32'h0);
      @(posedge CLOCK);
      chk_word({28'h0, OP_POINT}, 32'h0);
      wr(8'h10, 32'hc);
      wait_for(1, 1'b1);
      wait_for(1, 1'b0);
      CORE_IRQ_IN <= 1'b1;
      @(posedge CLOCK);
      CORE_IRQ_IN <= 1'b0;
      @(posedge CLOCK);
      chk_bit(CORE_IRQ_OUT, 1'b0);
      wait_for(2, 1'b1);
      chk_bit(CORE_CLK_EN, 1'b1);
      @(posedge CLOCK);
      chk_bit(CORE_IRQ_OUT, 1'b0);
      tgt <= 8'h62;
      repeat (40) @(posedge CLOCK);
      chk_bit(OVER_TEMP_OUT_N, 1'b0);
      tgt <= 8'h61;
      wait_for(0, 1'b1);
      rd_reg(8'h08);
      chk_word(rd, 32'h6);
      chk_word({28'h0, OP_POINT}, 32'hc);
      meas(SLP, SLP, 1'b0);
   endtask
   task automatic t_low();
      wr(8'h0c, 32'h0);
      wr(8'h10, 32'h0);
      @(posedge CLOCK);
      chk_word({28'h0, OP_POINT}, 32'h0);
      wr(8'h10, 32'hf);
      for (int d = 1; d < 8; d++) begin
         wr(8'h00, 32'h10 | 32'(d << 1));
         meas(SLP, SLP * d / 8, 1'b1);
      end
      wr(8'h00, 32'h112);
      fast <= 1'b1;
      tgt <= 8'h64;
      meas(SLP, SLP / 2, 1'b1);
      wr(8'h1c, 32'h80);
      meas(SLQ, SLQ / 2, 1'b1);
   endtask
   // Reset for ten cycles, then the scenarios in turn
   initial begin
      SYS_RST = 1'b1;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY, CORE_IRQ_IN, fast} = '0;
      {AWADDR, ARADDR, WDATA} = '0;
      WSTRB = 4'hf;
      tgt = 8'h19;
      repeat (10) @(posedge CLOCK);
      SYS_RST <= 1'b0;
      t_reset();
      t_hot();
      t_low();
      stop_test();
   end
endmodule
`default_nettype wire

/* File: tb/ttc_sensor_model.sv */
// Sensor model: die temperature moving toward a bench target.
// Assumes the bench sets target; fast jumps, otherwise one degree a cycle.
`timescale 1ns/1ps
`default_nettype none
module ttc_sensor_model (
   // Clock
   input wire logic CLOCK,
   // Target and pace
   input wire logic [7:0] target,
   input wire logic fast,
   // Reading
   output logic [7:0] die_temp
);
   // Slow pace crosses every threshold, so no level is skipped
   initial die_temp = 8'h19;
   always @(posedge CLOCK) begin
      if (fast) die_temp <= target;
      else if (die_temp < target) die_temp <= die_temp + 8'h01;
      else if (die_temp > target) die_temp <= die_temp - 8'h01;
   end
endmodule
`default_nettype wire

/* File: tb/ttc_sva.sv */
// Checker on the thermal throttle controller top ports.
// Assumes it is bound onto ttc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ttc_sva (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic SYS_RST,
   // Register bus
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   input wire logic RREADY,
   // Thermal and core
   input wire logic [7:0] DIE_TEMP,
   input wire logic CORE_IRQ_IN,
   input wire logic CORE_IRQ_OUT,
   input wire logic CORE_CLK_EN,
   input wire logic OVER_TEMP_OUT_N
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SYS_RST);
   sequence s_wr_both;
      AWVALID && AWREADY && WVALID && WREADY;
   endsequence
   sequence s_rd_taken;
      ARVALID && ARREADY;
   endsequence
   chk_hot_rise: assert property (
      DIE_TEMP >= 8'h64 |=> !OVER_TEMP_OUT_N)
      else $error("hot output missing");
   chk_hyst_hold: assert property (
      !OVER_TEMP_OUT_N && DIE_TEMP >= 8'h62 |=> !OVER_TEMP_OUT_N)
      else $error("hot output dropped early");
   chk_hot_release: assert property (
      !OVER_TEMP_OUT_N && DIE_TEMP < 8'h62 |=> OVER_TEMP_OUT_N)
      else $error("hot output stuck");
   chk_irq_gate: assert property (
      CORE_IRQ_IN |=> CORE_IRQ_OUT == CORE_CLK_EN)
      else $error("request not served while clock runs");
   chk_irq_latch: assert property (
      CORE_IRQ_IN |-> ##[1:1000] CORE_IRQ_OUT)
      else $error("request lost");
   chk_write_resp: assert property (s_wr_both |-> ##[1:2] BVALID)
      else $error("write answer late");
   chk_read_resp: assert property (s_rd_taken |=> RVALID)
      else $error("read answer late");
   chk_b_hold: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write answer withdrawn");
   chk_r_hold: assert property (RVALID && !RREADY |=> RVALID)
      else $error("read answer withdrawn");
endmodule
bind ttc_top ttc_sva u_ttc_sva (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
   .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
   .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
   .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
   .DIE_TEMP(DIE_TEMP), .CORE_IRQ_IN(CORE_IRQ_IN),
   .CORE_IRQ_OUT(CORE_IRQ_OUT), .CORE_CLK_EN(CORE_CLK_EN),
   .OVER_TEMP_OUT_N(OVER_TEMP_OUT_N));
`default_nettype wire
